// >>> pkg/wsd_regs.vh
`ifndef WSD_REGS_VH
`define WSD_REGS_VH
// ==========================================
// register sub-addresses
`define WSD_ADDR_F1_LOW 8'h14
`define WSD_ADDR_F1_HIGH 8'h15
`define WSD_ADDR_F2_LOW 8'h16
`define WSD_ADDR_F2_HIGH 8'h17
`define WSD_ADDR_F1_CHECK 8'h18
// ==========================================
// reset values and fields
`define WSD_RST_LOW 8'h00
`define WSD_RST_HIGH 6'h00
`define WSD_RST_CHECK 6'h3f
`define WSD_PAYLOAD_BITS 5'd14
`define WSD_NTSC_BITS 5'd20
`define WSD_CNT_IDLE 5'd0
`define WSD_CNT_LAST 5'd1
`define WSD_SHIFT_RST 20'h00000
`define WSD_CHECK_PAD 6'h00
`define WSD_RSVD_PAD 2'b00
`define WSD_RDATA_NONE 8'h00
`define WSD_RST_F2_DONE 1'b1
// ==========================================
// line numbers
`define WSD_F1_LINE_A 9'd17
`define WSD_F1_LINE_B 9'd20
`define WSD_F1_LINE_C 9'd23
`define WSD_F2_LINE_A 9'd280
`define WSD_F2_LINE_B 9'd283
`define WSD_F2_LINE_C 9'd336
`endif

// >>> verilog/wsd_fifo.v
// the bit fifo module is kept beside the serializer, in one design file

// >>> verilog/wsd_serializer.v
// Function
// - field one word sent lines 17/20/23
// - field two word sent lines 280/283/336
// - low byte bit 0 first, upward
// - high bits 7-6 never sent
// - ntsc appends check after field one payload only
// - pal omits check value
// - check value sent bit 0 first
// - field two status set after sending
`timescale 1ns/10ps
`include "wsd_regs.vh"
module wsd_serializer (
  input wire core_clk_i,
  input wire rst_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire widescreen_signalling_en_i,
  input wire ntsc_mode_i,
  input wire line_start_i,
  input wire [8:0] line_num_i,
  input wire bit_strobe_i,
  output wire bit_valid_o,
  input wire bit_ready_i,
  output wire bit_data_o,
  output reg field2_written_o
);
  // ==========================================
  // registers
  reg [7:0] f1_low_q;
  reg [5:0] f1_high_q;
  reg [7:0] f2_low_q;
  reg [5:0] f2_high_q;
  reg [5:0] f1_check_q;
  reg [19:0] shift_q;
  reg [4:0] left_q;
  reg f2_busy_q;
  wire fifo_ready;

  function is_line;
    input [8:0] n;
    input [8:0] a;
    input [8:0] b;
    input [8:0] c;
    begin
      is_line = (n == a) || (n == b) || (n == c);
    end
  endfunction

  // ==========================================
  // line decode and pacing
  wire f1_line;
  wire f2_line;
  wire idle;
  wire start;
  wire wr_f2;
  wire push;
  wire done;

  assign f1_line = is_line(line_num_i, `WSD_F1_LINE_A, `WSD_F1_LINE_B, `WSD_F1_LINE_C);
  assign f2_line = is_line(line_num_i, `WSD_F2_LINE_A, `WSD_F2_LINE_B, `WSD_F2_LINE_C);
  assign idle = (left_q == `WSD_CNT_IDLE);
  // a start on a busy or disabled line is dropped, not queued
  assign start = line_start_i && widescreen_signalling_en_i && idle && (f1_line || f2_line);
  assign wr_f2 = reg_wr_i && ((reg_addr_i == `WSD_ADDR_F2_LOW) || (reg_addr_i == `WSD_ADDR_F2_HIGH));
  // fifo back-pressure stalls the shift, so no bit is ever lost
  assign push = !idle && bit_strobe_i && fifo_ready;
  assign done = push && (left_q == `WSD_CNT_LAST);

  // ==========================================
  // host register writes
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      f1_low_q <= `WSD_RST_LOW;
      f1_high_q <= `WSD_RST_HIGH;
      f2_low_q <= `WSD_RST_LOW;
      f2_high_q <= `WSD_RST_HIGH;
      f1_check_q <= `WSD_RST_CHECK;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `WSD_ADDR_F1_LOW: f1_low_q <= reg_wdata_i;
        `WSD_ADDR_F1_HIGH: f1_high_q <= reg_wdata_i[5:0];
        `WSD_ADDR_F2_LOW: f2_low_q <= reg_wdata_i;
        `WSD_ADDR_F2_HIGH: f2_high_q <= reg_wdata_i[5:0];
        `WSD_ADDR_F1_CHECK: f1_check_q <= reg_wdata_i[5:0];
        default: f1_low_q <= f1_low_q;
      endcase
    end
  end

  always @* begin
    case (reg_addr_i)
      `WSD_ADDR_F1_LOW: reg_rdata_o = f1_low_q;
      `WSD_ADDR_F1_HIGH: reg_rdata_o = {`WSD_RSVD_PAD, f1_high_q};
      `WSD_ADDR_F2_LOW: reg_rdata_o = f2_low_q;
      `WSD_ADDR_F2_HIGH: reg_rdata_o = {`WSD_RSVD_PAD, f2_high_q};
      `WSD_ADDR_F1_CHECK: reg_rdata_o = {`WSD_RSVD_PAD, f1_check_q};
      default: reg_rdata_o = `WSD_RDATA_NONE;
    endcase
  end

  // ==========================================
  // serializer: shift copy so registers stay untouched
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_q <= `WSD_SHIFT_RST;
      left_q <= `WSD_CNT_IDLE;
      f2_busy_q <= 1'b0;
    end else if (start) begin
      f2_busy_q <= f2_line;
      if (f1_line) begin
        shift_q <= {f1_check_q, f1_high_q, f1_low_q};
      end else begin
        shift_q <= {`WSD_CHECK_PAD, f2_high_q, f2_low_q};
      end
      left_q <= (ntsc_mode_i && f1_line) ? `WSD_NTSC_BITS : `WSD_PAYLOAD_BITS;
    end else if (push) begin
      shift_q <= {1'b0, shift_q[19:1]};
      left_q <= left_q - `WSD_CNT_LAST;
    end
  end

  // ==========================================
  // status: completion wins over a same-cycle host write
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      field2_written_o <= `WSD_RST_F2_DONE;
    end else if (done && f2_busy_q) begin
      field2_written_o <= 1'b1;
    end else if (wr_f2) begin
      field2_written_o <= 1'b0;
    end
  end

  wsd_fifo #(.WIDTH(1), .DEPTH(4), .AW(2)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(shift_q[0]),
    .out_valid_o(bit_valid_o),
    .out_ready_i(bit_ready_i),
    .out_data_o(bit_data_o)
  );
endmodule // wsd_serializer

// ==========================================
// bit fifo between strobe pacing and the consumer
module wsd_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  // ==========================================
  // storage and pointers
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // ==========================================
  // pointer step
  // explicit wrap, so a depth that is not a power of two still works
  function [AW-1:0] next_ptr;
    input [AW-1:0] p;
    begin
      if ({1'b0, p} == DEPTH[AW:0] - 1'b1) begin
        next_ptr = {AW{1'b0}};
      end else begin
        next_ptr = p + 1'b1;
      end
    end
  endfunction

  // ==========================================
  // handshake flags
  // count is one bit wider than the pointers so full and empty differ
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  // head comes from storage, which is written only at the tail
  assign out_data_o = mem_q[rd_q];

  // ==========================================
  // storage
  // no reset here: the count keeps stale words from being seen
  always @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // ==========================================
  // pointers and fill count
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= next_ptr(wr_q);
      end
      if (pop) begin
        rd_q <= next_ptr(rd_q);
      end
      // simultaneous push and pop leave the count alone
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // wsd_fifo

// >>> verification/wsd_monitor.sv
`timescale 1ns/10ps
// ====
// port checks
module wsd_monitor (
  input wire core_clk_i,
  input wire rst_i,
  input wire reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire bit_strobe_i,
  input wire bit_valid_o,
  input wire bit_ready_i,
  input wire bit_data_o,
  input wire field2_written_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_rsvd_zero: assert property ((reg_addr_i == 8'h15) |-> reg_rdata_o[7:6] == 2'h0) else $error("rsvd");
  chk_low_back: assert property (reg_wr_i && reg_addr_i == 8'h14 ##1 reg_addr_i == 8'h14
    |-> reg_rdata_o == $past(reg_wdata_i)) else $error("low");
  chk_high_back: assert property (reg_wr_i && reg_addr_i == 8'h17 ##1 reg_addr_i == 8'h17
    |-> reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0])}) else $error("high");
  chk_bit_hold: assert property (bit_valid_o && !bit_ready_i |=> bit_valid_o && $stable(bit_data_o)) else $error("hold");
  chk_push_cause: assert property (!bit_valid_o && !bit_strobe_i |=> !bit_valid_o) else $error("push");
  chk_stat_cause: assert property ($rose(field2_written_o) |-> $past(bit_strobe_i)) else $error("stat");
  chk_stat_low: assert property (reg_wr_i && reg_addr_i == 8'h16 && field2_written_o |=> !field2_written_o)
    else $error("clr");
  chk_stat_high: assert property (reg_wr_i && reg_addr_i == 8'h17 && field2_written_o |=> !field2_written_o)
    else $error("clr");
  cover property (bit_valid_o && bit_ready_i);
  cover property ($rose(field2_written_o));
  cover property (reg_wr_i && reg_addr_i == 8'h18);
endmodule // wsd_monitor
bind wsd_serializer wsd_monitor i_wsd_monitor (.*);

// >>> verification/wsd_bit_sink.sv
`timescale 1ns/10ps
// ====
// consumer, stalls at random
module wsd_bit_sink (
  input wire core_clk_i,
  input wire clr_i,
  input wire bit_valid_i,
  input wire bit_data_i,
  output reg bit_ready_o,
  output reg [19:0] word_o,
  output reg [4:0] cnt_o
);
  initial bit_ready_o = 1'b0;
  always @(posedge core_clk_i) begin
    if (clr_i) begin
      word_o <= 20'h00000;
      cnt_o <= 5'd0;
    end else if (bit_valid_i && bit_ready_o) begin
      word_o[cnt_o] <= bit_data_i;
      cnt_o <= cnt_o + 5'd1;
    end
    bit_ready_o <= #1 ($urandom % 3) != 0;
  end
endmodule // wsd_bit_sink

// >>> verification/tb_widescreen_vbi_data_serializer.sv
`timescale 1ns/10ps
`include "wsd_regs.vh"
// ====
// bench
module tb_widescreen_vbi_data_serializer;
  reg core_clk_i = 0, rst_i = 1, reg_wr_i = 0, widescreen_signalling_en_i = 0, ntsc_mode_i = 0, line_start_i = 0;
  reg bit_strobe_i = 0, clr = 1;
  reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, l1, h1, ck, l2, h2;
  reg [8:0] line_num_i = 9'd0;
  wire [7:0] reg_rdata_o;
  wire bit_valid_o, bit_ready_i, bit_data_o, field2_written_o;
  wire [19:0] word;
  wire [4:0] cnt;
  integer err_total = 0, comparisons = 0, i;
  initial forever #12.5 core_clk_i = ~core_clk_i;
  wsd_serializer i_wsd_serializer (.*);
  wsd_bit_sink i_wsd_bit_sink (.core_clk_i(core_clk_i), .clr_i(clr), .bit_valid_i(bit_valid_o),
    .bit_data_i(bit_data_o), .bit_ready_o(bit_ready_i), .word_o(word), .cnt_o(cnt));
  always @(posedge core_clk_i) bit_strobe_i <= #1 $urandom % 2;
  function [19:0] expw(input [7:0] l, input [7:0] h, input [4:0] nb);
    expw = nb == 5'd20 ? {ck[5:0], h[5:0], l} : nb == 5'd14 ? {6'h00, h[5:0], l} : 20'h00000;
  endfunction
  task chk(input [19:0] seen, input [19:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wrr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk_i) #1 reg_wr_i = 1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge core_clk_i) #1 reg_wr_i = 0;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      reg_addr_i = a;
      #1 chk(reg_rdata_o, e);
    end
  endtask
  task frame(input [8:0] ln, input [7:0] l, input [7:0] h, input n, input [4:0] nb);
    begin
      ntsc_mode_i = n;
      line_num_i = ln;
      clr = 1;
      @(posedge core_clk_i) #1 clr = 0;
      line_start_i = 1;
      @(posedge core_clk_i) #1 line_start_i = 0;
      for (i = 0; i < 400 && cnt < nb; i = i + 1) @(posedge core_clk_i);
      // extra bits after the word must not appear
      repeat (40) @(posedge core_clk_i);
      #1 chk(cnt, nb);
      chk(word, expw(l, h, nb));
      $display("line %0d done", ln);
    end
  endtask
  task close_out;
    begin
      $display("compared %0d, mismatched %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #(25 * 30000) err_total = err_total + 1;
    close_out;
  end
  initial begin
    i = $urandom(32'h4d2b);
    repeat (2) @(posedge core_clk_i);
    #1 rst_i = 0;
    for (i = 20; i < 26; i = i + 1) rdc(i, i == 24 ? 8'h3f : 8'h00);
    chk(field2_written_o, 1);
    {l1, h1, ck, l2, h2} = {$urandom, $urandom};
    wrr(8'h14, l1);
    wrr(8'h15, h1 | 8'hc0);
    wrr(8'h18, ck);
    wrr(8'h17, h2);
    wrr(8'h16, l2);
    wrr(8'h1a, 8'hff);
    chk(field2_written_o, 0);
    rdc(8'h15, {2'h0, h1[5:0]});
    widescreen_signalling_en_i = 1;
    frame(`WSD_F1_LINE_A, l1, h1, 1, 20);
    frame(`WSD_F1_LINE_B, l1, h1, 0, 14);
    frame(`WSD_F1_LINE_C, l1, h1, 1, 20);
    frame(9'd21, l1, h1, 1, 0);
    frame(`WSD_F2_LINE_A, l2, h2, 0, 14);
    chk(field2_written_o, 1);
    frame(`WSD_F2_LINE_B, l2, h2, 1, 14);
    frame(`WSD_F2_LINE_C, l2, h2, 0, 14);
    widescreen_signalling_en_i = 0;
    frame(`WSD_F1_LINE_B, l1, h1, 1, 0);
    rdc(8'h14, l1);
    close_out;
  end
endmodule // tb_widescreen_vbi_data_serializer
